// ---- verilog/msirp_pkg.sv ----
// shared constants of the sensor register port: addresses, fields, reset values, timing
package msirp_pkg;
	// target address and direction
	localparam logic [6:0] TARGET_ADDR = 7'h4C;
	localparam logic DIR_WRITE = 1'b0;
	localparam logic DIR_READ = 1'b1;
	// register indices
	localparam logic [7:0] IDX_STATUS = 8'h03;
	localparam logic [7:0] IDX_OP_STATE = 8'h04;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h06;
	localparam logic [7:0] IDX_MODE = 8'h07;
	localparam logic [7:0] IDX_TAP_AXES = 8'h09;
	localparam logic [7:0] IDX_TAP_WIDTH = 8'h0A;
	localparam logic [7:0] IDX_FFALL = 8'h0B;
	localparam logic [7:0] IDX_SHAKE_DB = 8'h0C;
	localparam logic [7:0] IDX_XL = 8'h0D;
	localparam logic [7:0] IDX_XH = 8'h0E;
	localparam logic [7:0] IDX_YL = 8'h0F;
	localparam logic [7:0] IDX_YH = 8'h10;
	localparam logic [7:0] IDX_ZL = 8'h11;
	localparam logic [7:0] IDX_ZH = 8'h12;
	localparam logic [7:0] IDX_CHIP_ID = 8'h18;
	localparam logic [7:0] IDX_OUT_CFG = 8'h20;
	localparam logic [7:0] IDX_X_OFFSET = 8'h21;
	// burst read wrap points
	localparam logic [7:0] IDX_WRAP_LAST = IDX_ZH;
	localparam logic [7:0] IDX_WRAP_FIRST = IDX_STATUS;
	// reset values
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_MODE = 8'h03;
	localparam logic [7:0] RST_OUTPUT_CONFIGURATION = 8'h03;
	localparam logic [15:0] RST_SAMPLE = 16'h0000;
	// operating state encoding in the low two mode bits
	localparam logic [1:0] OPCON_WAKE = 2'h1;
	localparam logic [1:0] OPCON_STANDBY = 2'h3;
	// bit counter marks: last data bit and acknowledge slot
	localparam logic [3:0] CNT_LAST_DATA = 4'h7;
	localparam logic [3:0] CNT_ACK = 4'h8;
	localparam logic [3:0] CNT_ZERO = 4'h0;
	localparam logic [3:0] CNT_ONE = 4'h1;
	localparam logic [7:0] IDX_STEP = 8'h01;
	// identity value, arbitrary
	localparam logic [7:0] CHIP_ID_VALUE = 8'hA5;
	// link timing: fastest bus clock and the core clock period
	localparam int SCL_MAX_KHZ = 400;
	localparam int CORE_PERIOD_NS = 40;
	localparam int SCL_MIN_PERIOD_NS = 1000000 / SCL_MAX_KHZ;
	localparam int SCL_MIN_PERIOD_CYC = SCL_MIN_PERIOD_NS / CORE_PERIOD_NS;
	// protocol states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_INDEX,
		ST_WDATA,
		ST_RDATA,
		ST_IGNORE
	} msirp_state_e;
endpackage

// ---- verilog/msirp_link_sampler.sv ----
// link-side data sampler clocked by the serial clock
`timescale 1ns/10ps
module msirp_link_sampler (
	// link clock and reset
	input wire logic scl_clk,
	input wire logic rst_n,
	// data pin level
	input wire logic sda_i,
	// sampled bit and its event toggle
	output logic link_bit,
	output logic link_tgl
);
	// sda is valid at the rising clock; the bit stays put until the next rise,
	// long enough for the core side to pick it up after the toggle crosses
	always_ff @(posedge scl_clk or negedge rst_n) begin
		if (!rst_n) begin
			link_bit <= 1'b1;
			link_tgl <= 1'b0;
		end else begin
			link_bit <= sda_i;
			link_tgl <= ~link_tgl;
		end
	end
endmodule

// ---- verilog/msirp_top.sv ----
// serial target port with register map of the motion sensor
`timescale 1ns/10ps
module msirp_top (
	// core clock, reset, enable
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// serial link: clock as domain clock and as pin level, data as open drain
	input wire logic scl_clk,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	// sample path from the sensing logic
	input wire logic sample_valid,
	input wire logic [15:0] x_axis_sample,
	input wire logic [15:0] y_axis_sample,
	input wire logic [15:0] z_axis_sample,
	input wire logic [2:0] portrait_landscape_field,
	input wire logic [1:0] face_up_down_field,
	// event pulses and one-time-programming flags
	input wire logic shake_event_flag,
	input wire logic freefall_event_flag,
	input wire logic tap_event_flag,
	input wire logic otp_active_flag,
	input wire logic otp_error_flag,
	// configuration towards the sensing logic
	output logic [7:0] interrupt_enable_mask,
	output logic [7:0] operating_mode_control,
	output logic [7:0] tap_axis_enable,
	output logic [7:0] tap_pulse_width,
	output logic [7:0] freefall_control,
	output logic [7:0] shake_debounce_count,
	output logic [7:0] output_configuration,
	output logic [7:0] x_offset_low,
	output logic [1:0] current_state_field
);
	import msirp_pkg::*;

	// pin synchronisers and the crossed link toggle
	logic scl_s1, scl_s2, scl_s3;
	logic sda_s1, sda_s2, sda_s3;
	logic tgl_s1, tgl_s2, tgl_s3;
	logic link_bit; // stable sampled bit from the link domain
	logic link_tgl; // flips once per link clock rise
	// protocol state
	msirp_state_e st;
	logic [3:0] cnt; // bits seen in the current byte, 8 is the ack slot
	logic [6:0] rx; // first seven bits of the byte
	logic ack_pend; // acknowledge owed in the next ack slot
	logic rw; // direction of the transfer
	logic busy; // between start and stop
	logic [7:0] idx; // register index
	logic [7:0] tx; // byte being shifted out
	// held register contents
	logic [2:0] ev_flags; // shake, freefall, tap (sticky)
	logic [2:0] ev_pend; // events waiting for the bus to go quiet
	logic [2:0] orient_q; // portrait or landscape field, live per sample
	logic [1:0] facing_q; // face up or down field, live per sample
	logic [15:0] x_q, y_q, z_q;

	// data sampling in the link domain
	msirp_link_sampler u_link (
		.scl_clk(scl_clk),
		.rst_n(rst_n),
		.sda_i(sda_i),
		.link_bit(link_bit),
		.link_tgl(link_tgl)
	);

	// two flops per foreign input, a third only for edge detection
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			{scl_s1, scl_s2, scl_s3} <= 3'h7;
			{sda_s1, sda_s2, sda_s3} <= 3'h7;
			{tgl_s1, tgl_s2, tgl_s3} <= 3'h0;
		end else if (clk_en) begin
			{scl_s1, scl_s2, scl_s3} <= {scl_i, scl_s1, scl_s2};
			{sda_s1, sda_s2, sda_s3} <= {sda_i, sda_s1, sda_s2};
			{tgl_s1, tgl_s2, tgl_s3} <= {link_tgl, tgl_s1, tgl_s2};
		end
	end

	// bus conditions and bit events
	wire scl_fall = scl_s3 & ~scl_s2;
	wire start_det = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
	wire stop_det = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
	wire bit_evt = tgl_s2 ^ tgl_s3;
	wire [7:0] byte_val = {rx, link_bit};
	wire byte_done = bit_evt && (cnt == CNT_LAST_DATA);
	wire ack_evt = bit_evt && (cnt == CNT_ACK);
	wire addr_match = (byte_val[7:1] == TARGET_ADDR);
	wire standby = (operating_mode_control[1:0] != OPCON_WAKE);
	wire [7:0] rd_next = (idx == IDX_WRAP_LAST) ? IDX_WRAP_FIRST : idx + IDX_STEP;
	wire master_ack = ack_evt && (st == ST_RDATA) && !link_bit;
	wire first_load = ack_evt && (st == ST_ADDR) && ack_pend && (rw == DIR_READ);
	wire [7:0] load_idx = first_load ? idx : rd_next;
	wire tx_load = first_load || master_ack;
	wire wr_fire = byte_done && (st == ST_WDATA);
	wire wr_allowed = standby || (idx == IDX_MODE);
	wire [2:0] tx_pos = 3'(CNT_LAST_DATA - cnt);
	wire status_clr = tx_load && (load_idx == IDX_STATUS) && !standby;
	wire quiet = !busy;
	wire [7:0] status_val = {ev_flags, orient_q, facing_q};
	wire [7:0] opstate_val = {otp_active_flag, 1'b0, otp_error_flag, 3'h0,
		operating_mode_control[1:0]};

	// read-back mux; unlisted indices read zero
	function automatic logic [7:0] reg_read(input logic [7:0] a);
		case (a)
			IDX_STATUS: reg_read = status_val;
			IDX_OP_STATE: reg_read = opstate_val;
			IDX_IRQ_MASK: reg_read = interrupt_enable_mask;
			IDX_MODE: reg_read = operating_mode_control;
			IDX_TAP_AXES: reg_read = tap_axis_enable;
			IDX_TAP_WIDTH: reg_read = tap_pulse_width;
			IDX_FFALL: reg_read = freefall_control;
			IDX_SHAKE_DB: reg_read = shake_debounce_count;
			IDX_XL: reg_read = x_q[7:0];
			IDX_XH: reg_read = x_q[15:8];
			IDX_YL: reg_read = y_q[7:0];
			IDX_YH: reg_read = y_q[15:8];
			IDX_ZL: reg_read = z_q[7:0];
			IDX_ZH: reg_read = z_q[15:8];
			IDX_CHIP_ID: reg_read = CHIP_ID_VALUE;
			IDX_OUT_CFG: reg_read = output_configuration;
			IDX_X_OFFSET: reg_read = x_offset_low;
			default: reg_read = RST_ZERO;
		endcase
	endfunction

	// start, stop and byte framing
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= ST_IDLE;
			cnt <= CNT_ZERO;
			rx <= 7'h00;
			ack_pend <= 1'b0;
			rw <= DIR_WRITE;
			busy <= 1'b0;
		end else if (clk_en) begin
			if (start_det) begin
				// start or repeated start: expect the address byte
				st <= ST_ADDR;
				cnt <= CNT_ZERO;
				ack_pend <= 1'b0;
				busy <= 1'b1;
			end else if (stop_det) begin
				// stop frees the bus for new samples
				st <= ST_IDLE;
				cnt <= CNT_ZERO;
				ack_pend <= 1'b0;
				busy <= 1'b0;
			end else if (bit_evt && st != ST_IDLE) begin
				if (cnt == CNT_ACK) begin
					// ack slot done: pick the next phase
					cnt <= CNT_ZERO;
					ack_pend <= 1'b0;
					case (st)
						ST_ADDR: st <= (rw == DIR_READ) ? ST_RDATA : ST_INDEX;
						ST_INDEX: st <= ST_WDATA;
						ST_RDATA: st <= link_bit ? ST_IGNORE : ST_RDATA;
						default: st <= st;
					endcase
				end else begin
					rx <= byte_val[6:0];
					cnt <= cnt + CNT_ONE;
					if (cnt == CNT_LAST_DATA) begin
						case (st)
							ST_ADDR: begin
								// own address only; others are left alone
								ack_pend <= addr_match;
								rw <= link_bit;
								st <= addr_match ? ST_ADDR : ST_IGNORE;
							end
							ST_INDEX: ack_pend <= 1'b1;
							ST_WDATA: ack_pend <= 1'b1;
							default: ack_pend <= 1'b0;
						endcase
					end
				end
			end
		end
	end

	// data line: changes after the clock falls or is released on start and stop, never driven high
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sda_o <= 1'b0;
			sda_oe <= 1'b0;
		end else if (clk_en) begin
			sda_o <= 1'b0;
			if (start_det || stop_det) begin
				sda_oe <= 1'b0;
			end else if (scl_fall) begin
				if (st == ST_RDATA && cnt <= CNT_LAST_DATA) begin
					sda_oe <= ~tx[tx_pos];
				end else if (cnt == CNT_ACK && ack_pend) begin
					sda_oe <= 1'b1;
				end else begin
					sda_oe <= 1'b0;
				end
			end
		end
	end

	// index and outgoing byte
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			idx <= RST_ZERO;
			tx <= RST_ZERO;
		end else if (clk_en) begin
			if (byte_done && st == ST_INDEX) begin
				idx <= byte_val;
			end else if (wr_fire) begin
				idx <= idx + IDX_STEP;
			end else if (master_ack) begin
				idx <= rd_next;
			end
			if (tx_load) begin
				tx <= reg_read(load_idx);
			end
		end
	end

	// writable registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			interrupt_enable_mask <= RST_ZERO;
			operating_mode_control <= RST_MODE;
			tap_axis_enable <= RST_ZERO;
			tap_pulse_width <= RST_ZERO;
			freefall_control <= RST_ZERO;
			shake_debounce_count <= RST_ZERO;
			output_configuration <= RST_OUTPUT_CONFIGURATION;
			x_offset_low <= RST_ZERO;
		end else if (clk_en && wr_fire && wr_allowed) begin
			case (idx)
				IDX_IRQ_MASK: interrupt_enable_mask <= byte_val;
				IDX_MODE: operating_mode_control <= byte_val;
				IDX_TAP_AXES: tap_axis_enable <= byte_val;
				IDX_TAP_WIDTH: tap_pulse_width <= byte_val;
				IDX_FFALL: freefall_control <= byte_val;
				IDX_SHAKE_DB: shake_debounce_count <= byte_val;
				IDX_OUT_CFG: output_configuration <= byte_val;
				IDX_X_OFFSET: x_offset_low <= byte_val;
				default: x_offset_low <= x_offset_low;
			endcase
		end
	end

	// state field mirror for the sensing logic
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			current_state_field <= RST_MODE[1:0];
		end else if (clk_en) begin
			current_state_field <= operating_mode_control[1:0];
		end
	end

	// events wait while busy; a new event beats a same-cycle clear
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ev_pend <= 3'h0;
			ev_flags <= 3'h0;
		end else if (clk_en) begin
			ev_pend <= (quiet ? 3'h0 : ev_pend) |
				{shake_event_flag, freefall_event_flag, tap_event_flag};
			ev_flags <= (status_clr ? 3'h0 : ev_flags) |
				(quiet ? ev_pend : 3'h0);
		end
	end

	// samples and orientation only load while no transfer runs
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			x_q <= RST_SAMPLE;
			y_q <= RST_SAMPLE;
			z_q <= RST_SAMPLE;
			orient_q <= 3'h0;
			facing_q <= 2'h0;
		end else if (clk_en && sample_valid && quiet) begin
			x_q <= x_axis_sample;
			y_q <= y_axis_sample;
			z_q <= z_axis_sample;
			orient_q <= portrait_landscape_field;
			facing_q <= face_up_down_field;
		end
	end

	// checks on the core domain
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	property p_never_high;
		sda_o == 1'b0;
	endproperty
	a_never_high: assert property (p_never_high) else $error("data driven high");

	property p_foreign_quiet;
		(st == ST_IGNORE) && $past(st == ST_IGNORE) && scl_fall |=> !sda_oe;
	endproperty
	a_foreign_quiet: assert property (p_foreign_quiet) else $error("line held");

	property p_own_ack;
		clk_en && byte_done && (st == ST_ADDR) && addr_match && !start_det && !stop_det
			|=> ack_pend ##[1:200] sda_oe;
	endproperty
	a_own_ack: assert property (p_own_ack) else $error("own address not acked");

	property p_wrap;
		clk_en && master_ack && !start_det && !stop_det && (idx == IDX_WRAP_LAST)
			|=> idx == IDX_WRAP_FIRST;
	endproperty
	a_wrap: assert property (p_wrap) else $error("burst did not wrap");

	property p_busy_hold;
		busy && $past(busy) |-> $stable(x_q) && $stable(orient_q);
	endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("sample moved mid-transfer");

	property p_wake_lock;
		clk_en && wr_fire && !standby |=> $stable(interrupt_enable_mask)
			&& $stable(output_configuration);
	endproperty
	a_wake_lock: assert property (p_wake_lock) else $error("write in wake");

	property p_state_layout;
		(opstate_val[6] == 1'b0) && (opstate_val[4:2] == 3'h0)
			&& (opstate_val[1:0] == operating_mode_control[1:0]);
	endproperty
	a_state_layout: assert property (p_state_layout) else $error("state layout");

	property p_sticky;
		ev_flags[2] && !status_clr |=> ev_flags[2];
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag lost");

	property p_standby_keep;
		standby && clk_en |=> !$fell(ev_flags[2]) && !$fell(ev_flags[0]);
	endproperty
	a_standby_keep: assert property (p_standby_keep) else $error("flag cleared");

	property p_step;
		clk_en && wr_fire && !start_det && !stop_det |=> idx == $past(idx) + IDX_STEP;
	endproperty
	a_step: assert property (p_step) else $error("index did not advance");

	c_write: cover property (wr_fire && wr_allowed);
	c_read: cover property (first_load ##[1:900] master_ack);
	c_wrap: cover property (master_ack && idx == IDX_WRAP_LAST);
	c_foreign: cover property (byte_done && st == ST_ADDR && !addr_match);
endmodule

// ---- tb/msirp_host_model.sv ----
// bit-level serial controller model driving the clock and data wires
`timescale 1ns/10ps
module msirp_host_model (
	// clock and data release towards the wires
	output logic scl,
	output logic sda_rel,
	// resolved data wire
	input wire logic sda
);
	// quarter of a 2.5 us period keeps the bus clock at 400 kHz
	localparam time Q = 625ns;
	// both wires idle released; the clock stands still between frames
	initial begin
		scl = 1'b1;
		sda_rel = 1'b1;
	end
	// one clock pulse: data set mid-low, wire sampled mid-high
	task automatic bit_x(input logic b, output logic s);
		sda_rel = b;
		#Q scl = 1'b1;
		#Q s = sda;
		#Q scl = 1'b0;
		#Q;
	endtask
	// start or repeated start: data falls while the clock is high
	task automatic start();
		#13ns sda_rel = 1'b1;
		#Q scl = 1'b1;
		#Q sda_rel = 1'b0;
		#Q scl = 1'b0;
		#Q;
	endtask
	// stop: data rises while the clock is high
	task automatic stop();
		sda_rel = 1'b0;
		#Q scl = 1'b1;
		#Q sda_rel = 1'b1;
		#Q;
	endtask
	// byte out msb first; ack slot level returned, low means taken
	task automatic put(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], s);
		end
		bit_x(1'b1, ack);
	endtask
	// byte in msb first, then our acknowledge (0) or refusal (1)
	task automatic get(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, d[i]);
		end
		bit_x(last, s);
	endtask
endmodule

// ---- tb/tb.sv ----
// self-checking bench of the sensor register port
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
	$display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb;
	import msirp_pkg::*;
	// core side stimulus
	logic core_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, sample_valid = 1'b0;
	logic [15:0] xs = 16'h0000, ys = 16'h0000, zs = 16'h0000;
	logic [4:0] ori = 5'h00;
	logic [2:0] ev = 3'h0, pend = 3'h0;
	logic [1:0] otp = 2'h0, cur;
	// configuration outputs
	logic [7:0] irq_mask, mode, tap_axes, tap_width, ffc, shake_db, out_cfg, x_off;
	// serial wires and data pin of the device
	wire scl, sda_rel, sda;
	logic sda_o, sda_oe, ack;
	logic [7:0] rb;
	// expected register contents
	logic [7:0] mir [256];
	int n_errors = 0, checked = 0;
	// pulled-up wire, low while either side pulls
	assign sda = sda_rel & ~sda_oe;
	initial begin
		forever #20 core_clk = ~core_clk;
	end
	msirp_host_model host (.scl(scl), .sda_rel(sda_rel), .sda(sda));
	msirp_top i_msirp_top (
		.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
		.scl_clk(scl), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
		.sample_valid(sample_valid), .x_axis_sample(xs), .y_axis_sample(ys),
		.z_axis_sample(zs), .portrait_landscape_field(ori[4:2]),
		.face_up_down_field(ori[1:0]), .shake_event_flag(ev[2]),
		.freefall_event_flag(ev[1]), .tap_event_flag(ev[0]),
		.otp_active_flag(otp[1]), .otp_error_flag(otp[0]),
		.interrupt_enable_mask(irq_mask), .operating_mode_control(mode),
		.tap_axis_enable(tap_axes), .tap_pulse_width(tap_width), .freefall_control(ffc),
		.shake_debounce_count(shake_db), .output_configuration(out_cfg),
		.x_offset_low(x_off), .current_state_field(cur)
	);
	// the data output may only ever pull low
	always @(posedge core_clk) begin
		if (rst_n) `CHK(sda_o, 1'b0)
	end
	// verdict and end of run
	task automatic close_out();
		if (n_errors == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// expected read value of one index
	function automatic logic [7:0] exp_rd(input logic [7:0] i);
		if (i == IDX_OP_STATE) return {otp[1], 1'b0, otp[0], 3'h0, mir[8'h07][1:0]};
		if (i == IDX_CHIP_ID) return CHIP_ID_VALUE;
		return mir[i];
	endfunction
	// read index step with the burst wrap
	function automatic logic [7:0] nxt(input logic [7:0] i);
		return (i == IDX_WRAP_LAST) ? IDX_WRAP_FIRST : i + 8'h01;
	endfunction
	// a write lands only on writable indices, and in wake only on the mode
	function automatic void mw(input logic [7:0] i, input logic [7:0] d);
		logic rw;
		rw = i inside {8'h06, 8'h07, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h20, 8'h21};
		if (rw && (mir[8'h07][1:0] != OPCON_WAKE || i == IDX_MODE)) mir[i] = d;
	endfunction
	// configuration outputs against the expected registers
	task automatic chk_cfg();
		`CHK({irq_mask, mode, tap_axes, tap_width}, {mir[8'h06], mir[8'h07], mir[8'h09], mir[8'h0A]})
		`CHK({ffc, shake_db, out_cfg, x_off}, {mir[8'h0B], mir[8'h0C], mir[8'h20], mir[8'h21]})
		`CHK(cur, mir[8'h07][1:0])
	endtask
	// write: index then n bytes, the first d, the rest random
	task automatic wr(input logic [7:0] i, input int n, input logic [7:0] d);
		logic [7:0] v;
		host.start();
		host.put({TARGET_ADDR, DIR_WRITE}, ack);
		`CHK(ack, 1'b0)
		host.put(i, ack);
		`CHK(ack, 1'b0)
		for (int k = 0; k < n; k++) begin
			v = (k == 0) ? d : 8'($urandom());
			if (i == IDX_MODE && k > 0) v[1:0] = OPCON_STANDBY;
			if (i == IDX_OUT_CFG) v[1:0] = 2'h3;
			host.put(v, ack);
			`CHK(ack, 1'b0)
			mw(i, v);
			i = i + 8'h01;
		end
		host.stop();
		repeat (6) @(posedge core_clk);
	endtask
	// read: index write, repeated start, n bytes compared
	task automatic rd(input logic [7:0] i, input int n);
		host.start();
		host.put({TARGET_ADDR, DIR_WRITE}, ack);
		host.put(i, ack);
		host.start();
		host.put({TARGET_ADDR, DIR_READ}, ack);
		`CHK(ack, 1'b0)
		for (int k = 0; k < n; k++) begin
			host.get(k == n - 1, rb);
			`CHK(rb, exp_rd(i))
			if (i == IDX_STATUS && mir[8'h07][1:0] == OPCON_WAKE) mir[i][7:5] = 3'h0;
			i = nxt(i);
		end
		host.stop();
		repeat (6) @(posedge core_clk);
	endtask
	// sample and event pulse in one cycle; while busy events wait in pend
	task automatic sense(input logic [2:0] e, input logic busy);
		logic [63:0] s;
		logic [4:0] o;
		s = {$urandom(), $urandom()};
		o = 5'($urandom());
		@(posedge core_clk);
		sample_valid <= 1'b1;
		{zs, ys, xs} <= s[47:0];
		ori <= o;
		ev <= e;
		@(posedge core_clk);
		sample_valid <= 1'b0;
		ev <= 3'h0;
		if (busy) begin
			pend = pend | e;
		end else begin
			for (int k = 0; k < 6; k++) mir[8'h0D + k] = s[8 * k +: 8];
			mir[8'h03] = {mir[8'h03][7:5] | e, o};
		end
	endtask
	// main sequence
	initial begin
		void'($urandom(41036));
		foreach (mir[k]) mir[k] = 8'h00;
		mir[8'h07] = RST_MODE;
		mir[8'h20] = RST_OUTPUT_CONFIGURATION;
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		chk_cfg();
		rd(8'h00, 20);
		rd(8'h18, 10);
		otp <= 2'($urandom());
		rd(IDX_OP_STATE, 1);
		// standby: all writable registers, plus read-only and reserved places
		wr(8'h06, 7, 8'($urandom()));
		wr(8'h20, 2, 8'hFF);
		wr(8'h0D, 1, 8'h5A);
		wr(8'h05, 1, 8'hC3);
		chk_cfg();
		rd(8'h05, 15);
		rd(8'h20, 2);
		// new sample after a stop, burst across the wrap
		sense(3'h7, 1'b0);
		rd(IDX_XL, 8);
		rd(IDX_STATUS, 1);
		rd(IDX_STATUS, 1);
		// wake: only the mode takes writes, status clears on read
		wr(IDX_MODE, 1, {6'h00, OPCON_WAKE});
		wr(IDX_IRQ_MASK, 1, ~mir[8'h06]);
		chk_cfg();
		rd(IDX_STATUS, 2);
		rd(IDX_STATUS, 1);
		// sample and events in mid-transfer are held back
		fork
			rd(IDX_XL, 6);
			begin
				repeat (300) @(posedge core_clk);
				sense(3'h5, 1'b1);
			end
		join
		mir[8'h03][7:5] = mir[8'h03][7:5] | pend;
		rd(IDX_STATUS, 1);
		rd(IDX_XL, 6);
		wr(IDX_MODE, 1, RST_MODE);
		// foreign address: no acknowledge, write not taken
		host.start();
		host.put({TARGET_ADDR ^ 7'h01, DIR_WRITE}, ack);
		`CHK(ack, 1'b1)
		host.put(IDX_IRQ_MASK, ack);
		`CHK(ack, 1'b1)
		host.put(8'h3C, ack);
		host.stop();
		rd(IDX_IRQ_MASK, 1);
		close_out();
	end
	// hang guard
	initial begin
		#3800us;
		n_errors++;
		close_out();
	end
endmodule
